// ### index_ops_context_save_restore.sv
// Master sequencer: index commands, context save (stop) and restore
// Function
// R1: Index commands: fetch, relative address, no arithmetic
// R2: Load index reads temp address, captures on trailing
// R3: Address path shows temp address, then data
// R4: Add index adds memory word to index
// R5: Store index writes index at temp address
// R6: Stop while inactive starts stop sequence immediately
// R7: Stop while active pends until eligible command
// R8: Stop waits arithmetic unit, saves status word
// R9: Then set active, protect; load temp address
// R10: Save area address loaded only by stop
// R11: Stop writes seven words from save area
// R12: Save writes use consecutive incrementing mode
// R13: Last save write releases scanner and mode
// R14: After save, clear active and halt
// R15: Halt accepts commands, or restarts pending stop
// R16: Entering stop clears its pending request
// R17: Restart sets active, loads temp address
// R18: Restart forces double, reads saved status
// R19: Restart reads command word, incrementing address
// R20: Index restore uses explicit increment, no consecutive
// R21: Restart starts arithmetic double load
// R22: Restore pointer and data words, sign extended
// R23: Restore status; continue if active else halt
// R24: Memory request held until synchronized resume rises
`default_nettype none
module index_ops_context_save_restore
   import fpu_seq_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // APB slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Direct memory channel
   output logic memReq,
   output logic memWrite,
   output logic [15:0] memAddr,
   output logic [15:0] memWdata,
   input wire logic [15:0] memRdata,
   input wire logic memResume,
   output logic scannerHold,
   output logic consecutiveCycle,
   // Arithmetic unit
   input wire logic arithBusy,
   input wire logic arithDivFault,
   input wire logic arithOverflow,
   input wire logic arithUnderflow,
   input wire logic [15:0] accHigh,
   input wire logic [15:0] accMid,
   input wire logic [15:0] accLow,
   output logic arithStart,
   output logic [1:0] arithFunc,
   output logic [19:0] mdHigh,
   output logic [15:0] mdMid,
   output logic [15:0] mdLow
);
   seq_state_type state_q;
   mem_phase_type memPhase_q;
   logic [5:0] status_q;
   logic [5:0] savedStatus_q;
   logic [15:0] cmd_q, index_q, pointer_q, tar_q, saveArea_q;
   logic [15:0] memAddr_q, memWdata_q;
   logic [19:0] mdHigh_q;
   logic [15:0] mdMid_q, mdLow_q;
   logic [2:0] word_q;
   logic cmdValid_q, stopPending_q, stopPending_d, arithStart_q;
   logic resumeS1_q, resumeS2_q, resumePrev_q;
   logic [15:0] rdataS1_q, rdataS2_q;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic apbWrite, stopCmd, restartCmd, cmdWrite, ptrWrite, mapped;
   logic memRise, memFall, memDone, inMem, lastWord, ccMode, enterStop;
   logic explicitInc, indexStep, isAdd, isStore, eligible;
   logic [1:0] op;
   logic [15:0] dataAlu, addrAlu, saveWord;
   logic [31:0] readMux;

   // Two flops on every pin that the memory side drives
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         resumeS1_q <= 1'b0;
         resumeS2_q <= 1'b0;
         resumePrev_q <= 1'b0;
         rdataS1_q <= WORD_ZERO;
         rdataS2_q <= WORD_ZERO;
      end else begin
         resumeS1_q <= memResume;
         resumeS2_q <= resumeS1_q;
         resumePrev_q <= resumeS2_q;
         rdataS1_q <= memRdata;
         rdataS2_q <= rdataS1_q;
      end
   end

   assign memRise = resumeS2_q & ~resumePrev_q;
   assign memFall = ~resumeS2_q & resumePrev_q;
   assign memDone = (memPhase_q == MEM_RESP) && memFall;

   // APB decode; zero wait states
   assign apbWrite = psel & penable & pwrite;
   assign stopCmd = apbWrite && (paddr == ADDR_STOP);
   assign restartCmd = apbWrite && (paddr == ADDR_RESTART);
   assign cmdWrite = apbWrite && (paddr == ADDR_COMMAND);
   assign ptrWrite = apbWrite && (paddr == ADDR_POINTER);
   assign pready = psel & penable;
   assign prdata = prdata_q;
   assign pslverr = pslverr_q & psel & penable;

   always_comb begin
      mapped = 1'b1;
      readMux = 32'h00000000;
      case (paddr)
         ADDR_COMMAND: readMux = {16'h0000, cmd_q};
         ADDR_STOP, ADDR_RESTART: readMux = 32'h00000000;
         ADDR_SAVE_AREA: readMux = {16'h0000, saveArea_q};
         ADDR_STATUS: readMux = {26'h0000000, status_q};
         ADDR_INDEX: readMux = {16'h0000, index_q};
         ADDR_POINTER: readMux = {16'h0000, pointer_q};
         ADDR_TEMP_ADDR: readMux = {16'h0000, tar_q};
         default: mapped = 1'b0;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prdata_q <= 32'h00000000;
         pslverr_q <= 1'b0;
      end else if (psel && !penable) begin
         prdata_q <= readMux;
         pslverr_q <= ~mapped;
      end
   end

   // Command field decode
   assign op = cmd_q[CMD_OP_LSB +: 2];
   assign isAdd = (op == OP_ADD_INDEX);
   assign isStore = (op == OP_STORE_INDEX);
   assign eligible = (cmd_q[CMD_COUNT_LSB +: 3] != COUNT_FOUR)
      && !cmd_q[CMD_SPECIAL_BIT];
   assign lastWord = (word_q == WORD_ACC_LOW);
   assign inMem = (state_q == SEQ_FETCH) || (state_q == SEQ_INDEX)
      || (state_q == SEQ_SAVE) || (state_q == SEQ_RESTORE);
   assign explicitInc = (state_q == SEQ_RESTORE)
      && ((word_q == WORD_INDEX) || (word_q == WORD_POINTER)); // R20
   assign ccMode = ((state_q == SEQ_SAVE) || (state_q == SEQ_RESTORE))
      && !lastWord && !explicitInc; // R12 R13
   assign consecutiveCycle = ccMode;
   assign scannerHold = ((state_q == SEQ_SAVE) || (state_q == SEQ_RESTORE))
      && !lastWord; // R13
   assign indexStep = ((state_q == SEQ_INDEX) && !isStore)
      || ((state_q == SEQ_RESTORE) && (word_q == WORD_INDEX));

   // Address path: temp address while requesting, data during resume of index load, add and index restore
   assign dataAlu = ((state_q == SEQ_INDEX) && isAdd) ?
      16'(index_q + rdataS2_q) : rdataS2_q; // R4
   assign addrAlu = (resumeS2_q && indexStep) ? dataAlu : tar_q; // R3

   always_comb begin
      case (word_q)
         WORD_STATUS: saveWord = {10'h000, savedStatus_q};
         WORD_COMMAND: saveWord = cmd_q;
         WORD_INDEX: saveWord = index_q;
         WORD_POINTER: saveWord = pointer_q;
         WORD_ACC_HIGH: saveWord = accHigh;
         WORD_ACC_MID: saveWord = accMid;
         default: saveWord = accLow;
      endcase
   end

   // Request/resume engine shared by every memory step
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         memPhase_q <= MEM_IDLE;
      end else begin
         case (memPhase_q)
            MEM_IDLE: if (inMem) memPhase_q <= MEM_REQ;
            MEM_REQ: if (memRise) memPhase_q <= MEM_RESP; // R24
            MEM_RESP: if (memFall) memPhase_q <= MEM_IDLE;
            default: memPhase_q <= MEM_IDLE;
         endcase
      end
   end

   assign memReq = (memPhase_q == MEM_REQ);
   assign memWrite = (state_q == SEQ_SAVE)
      || ((state_q == SEQ_INDEX) && isStore);
   assign memAddr = memAddr_q;
   assign memWdata = memWdata_q;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         memAddr_q <= WORD_ZERO;
         memWdata_q <= WORD_ZERO;
      end else begin
         memAddr_q <= (state_q == SEQ_FETCH) ? pointer_q : addrAlu;
         memWdata_q <= (state_q == SEQ_SAVE) ? saveWord : index_q; // R5 R11
      end
   end

   // Sequencer
   assign enterStop = (state_q != SEQ_STOP_WAIT)
      && (((state_q == SEQ_HALT) && (stopPending_q || stopCmd))
      || ((state_q == SEQ_NEXT) && cmdValid_q && stopPending_q && eligible));

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= SEQ_HALT;
         word_q <= WORD_STATUS;
      end else begin
         case (state_q)
            SEQ_HALT: begin
               if (enterStop) state_q <= SEQ_STOP_WAIT; // R6 R15
               else if (restartCmd) state_q <= SEQ_RST_SETUP;
               else if (cmdValid_q) state_q <= SEQ_NEXT;
            end
            SEQ_NEXT: begin
               if (enterStop) state_q <= SEQ_STOP_WAIT; // R7
               else if (cmdValid_q) state_q <= SEQ_FETCH; // R1
            end
            SEQ_FETCH: if (memDone) state_q <= SEQ_INDEX; // R1
            SEQ_INDEX: if (memDone) state_q <= SEQ_NEXT;
            SEQ_STOP_WAIT: if (!arithBusy) state_q <= SEQ_STOP_SETUP; // R8
            SEQ_STOP_SETUP: begin
               state_q <= SEQ_SAVE;
               word_q <= WORD_STATUS;
            end
            SEQ_SAVE: begin
               if (memDone) begin
                  word_q <= 3'(word_q + 3'h1);
                  if (lastWord) state_q <= SEQ_SAVE_END; // R11
               end
            end
            SEQ_SAVE_END: state_q <= SEQ_HALT; // R14
            SEQ_RST_SETUP: begin
               state_q <= SEQ_RESTORE;
               word_q <= WORD_STATUS;
            end
            SEQ_RESTORE: begin
               if (memDone) begin
                  word_q <= 3'(word_q + 3'h1);
                  if (lastWord) state_q <= SEQ_RST_FINISH;
               end
            end
            SEQ_RST_FINISH: begin
               if (savedStatus_q[ST_ACTIVE]) state_q <= SEQ_NEXT; // R23
               else state_q <= SEQ_HALT;
            end
            default: state_q <= SEQ_HALT;
         endcase
      end
   end

   // Pending stop: a new stop in the clearing cycle survives only while active
   assign stopPending_d = (stopPending_q & ~enterStop)
      | (stopCmd & status_q[ST_ACTIVE]); // R7 R16

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) stopPending_q <= 1'b0;
      else stopPending_q <= stopPending_d;
   end

   // Save area address: only the stop command writes it
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) saveArea_q <= WORD_ZERO;
      else if (stopCmd) saveArea_q <= pwdata[15:0]; // R10
   end

   // Temp address register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tar_q <= WORD_ZERO;
      end else if ((state_q == SEQ_STOP_SETUP)
                   || (state_q == SEQ_RST_SETUP)) begin
         tar_q <= saveArea_q; // R9 R17
      end else if ((state_q == SEQ_FETCH) && memDone) begin
         tar_q <= 16'(rdataS2_q + pointer_q); // R1
      end else if ((memPhase_q == MEM_REQ) && memRise && ccMode) begin
         tar_q <= 16'(tar_q + ONE_WORD); // R12 R19
      end else if (explicitInc && memDone) begin
         tar_q <= 16'(tar_q + ONE_WORD); // R20
      end
   end

   // Status register; arithmetic flags set last so they win
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         status_q <= STATUS_RESET;
         savedStatus_q <= STATUS_RESET;
      end else begin
         case (state_q)
            SEQ_HALT: if (cmdValid_q && !enterStop && !restartCmd)
               status_q[ST_ACTIVE] <= 1'b1; // R15
            SEQ_STOP_WAIT: if (!arithBusy) savedStatus_q <= status_q; // R8
            SEQ_STOP_SETUP: begin
               status_q[ST_ACTIVE] <= 1'b1; // R9
               status_q[ST_PROTECT] <= 1'b1;
            end
            SEQ_SAVE_END: status_q[ST_ACTIVE] <= 1'b0; // R14
            SEQ_RST_SETUP: begin
               status_q[ST_ACTIVE] <= 1'b1; // R17
               status_q[ST_DOUBLE] <= 1'b1; // R18
            end
            SEQ_RESTORE: if (memDone && (word_q == WORD_STATUS))
               savedStatus_q <= rdataS2_q[5:0]; // R18
            SEQ_RST_FINISH: begin
               status_q[5:1] <= savedStatus_q[5:1]; // R23
               status_q[ST_ACTIVE] <= savedStatus_q[ST_ACTIVE];
            end
            default: status_q <= status_q;
         endcase
         if (arithDivFault) status_q[ST_DIV_FAULT] <= 1'b1;
         if (arithOverflow) status_q[ST_OVERFLOW] <= 1'b1;
         if (arithUnderflow) status_q[ST_UNDERFLOW] <= 1'b1;
      end
   end

   // Command register; a write in the dispatch cycle is kept
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cmd_q <= WORD_ZERO;
         cmdValid_q <= 1'b0;
      end else begin
         // A stop consumes the command too; it is saved, not run
         if ((state_q == SEQ_NEXT) && cmdValid_q)
            cmdValid_q <= 1'b0;
         if ((state_q == SEQ_RESTORE) && memDone
             && (word_q == WORD_COMMAND))
            cmd_q <= rdataS2_q; // R19
         if (cmdWrite) begin
            cmd_q <= pwdata[15:0];
            cmdValid_q <= 1'b1;
         end
      end
   end

   // Index and program pointer
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         index_q <= WORD_ZERO;
      end else if (memDone && indexStep) begin
         index_q <= dataAlu; // R2 R4 R20
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pointer_q <= WORD_ZERO;
      end else if ((state_q == SEQ_FETCH) && memDone) begin
         pointer_q <= 16'(pointer_q + ONE_WORD);
      end else if ((state_q == SEQ_RESTORE) && memDone
                   && (word_q == WORD_POINTER)) begin
         pointer_q <= rdataS2_q; // R22
      end else if (ptrWrite && !status_q[ST_ACTIVE]) begin
         pointer_q <= pwdata[15:0];
      end
   end

   // Memory data register and arithmetic start
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mdHigh_q <= 20'h00000;
         mdMid_q <= WORD_ZERO;
         mdLow_q <= WORD_ZERO;
         arithStart_q <= 1'b0;
      end else begin
         arithStart_q <= 1'b0;
         if ((state_q == SEQ_RESTORE) && memDone) begin
            case (word_q)
               WORD_ACC_HIGH:
                  mdHigh_q <= {{4{rdataS2_q[15]}}, rdataS2_q}; // R22
               WORD_ACC_MID: mdMid_q <= rdataS2_q;
               WORD_ACC_LOW: begin
                  mdLow_q <= rdataS2_q;
                  arithStart_q <= 1'b1; // R21
               end
               default: mdLow_q <= mdLow_q;
            endcase
         end
      end
   end

   assign arithStart = arithStart_q;
   assign arithFunc = FUNC_DOUBLE_LOAD;
   assign mdHigh = mdHigh_q;
   assign mdMid = mdMid_q;
   assign mdLow = mdLow_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   chk_req_held: assert property (memReq && !memRise |=> memReq) // R24
      else $error("request dropped before resume");
   chk_stop_idle: assert property (state_q == SEQ_HALT && stopCmd // R6
      |=> state_q == SEQ_STOP_WAIT)
      else $error("idle stop did not start sequence");
   chk_stop_gate: assert property (state_q == SEQ_NEXT && cmdValid_q // R7
      && !eligible |=> state_q == SEQ_FETCH)
      else $error("stop taken on ineligible command");
   chk_arith_wait: assert property (state_q == SEQ_STOP_WAIT // R8
      && arithBusy |=> state_q == SEQ_STOP_WAIT)
      else $error("stop ran ahead of arithmetic unit");
   chk_setup_tar: assert property (state_q == SEQ_STOP_SETUP // R9
      |=> tar_q == saveArea_q && status_q[ST_ACTIVE] && status_q[ST_PROTECT])
      else $error("stop setup wrong");
   chk_area_stable: assert property (!stopCmd |=> $stable(saveArea_q)) // R10
      else $error("save area address changed");
   chk_cc_step: assert property (memReq && memRise && ccMode // R12
      |=> tar_q == 16'($past(tar_q) + ONE_WORD))
      else $error("consecutive increment missing");
   chk_last_release: assert property (state_q == SEQ_SAVE && lastWord // R13
      |-> !scannerHold && !consecutiveCycle)
      else $error("scanner not released on last word");
   chk_index_load: assert property (state_q == SEQ_INDEX // R2
      && op == OP_LOAD_INDEX && memDone |=> index_q == $past(rdataS2_q))
      else $error("index load wrong");
   chk_double_load: assert property (state_q == SEQ_RESTORE && lastWord // R21
      && memDone |=> arithStart ##1 !arithStart)
      else $error("double load not started");
   chk_pending_clear: assert property (enterStop && !stopCmd // R16
      |=> !stopPending_q)
      else $error("stop request not cleared");
endmodule : index_ops_context_save_restore
`default_nettype wire

// ### fpu_seq_pkg.sv
// Constants and types for the index and context save/restore sequencer
`default_nettype none
package fpu_seq_pkg;
   // APB byte addresses
   localparam logic [7:0] ADDR_COMMAND = 8'h00;
   localparam logic [7:0] ADDR_STOP = 8'h04;
   localparam logic [7:0] ADDR_RESTART = 8'h08;
   localparam logic [7:0] ADDR_SAVE_AREA = 8'h0c;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_INDEX = 8'h14;
   localparam logic [7:0] ADDR_POINTER = 8'h18;
   localparam logic [7:0] ADDR_TEMP_ADDR = 8'h1c;
   // Command code fields
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_COUNT_LSB = 2;
   localparam int CMD_SPECIAL_BIT = 5;
   localparam logic [1:0] OP_LOAD_INDEX = 2'h0;
   localparam logic [1:0] OP_ADD_INDEX = 2'h1;
   localparam logic [1:0] OP_STORE_INDEX = 2'h2;
   localparam logic [2:0] COUNT_FOUR = 3'h4;
   // Status register bits
   localparam int ST_ACTIVE = 0;
   localparam int ST_PROTECT = 1;
   localparam int ST_DOUBLE = 2;
   localparam int ST_DIV_FAULT = 3;
   localparam int ST_OVERFLOW = 4;
   localparam int ST_UNDERFLOW = 5;
   localparam logic [5:0] STATUS_RESET = 6'h00;
   // Save area layout
   localparam logic [2:0] WORD_STATUS = 3'h0;
   localparam logic [2:0] WORD_COMMAND = 3'h1;
   localparam logic [2:0] WORD_INDEX = 3'h2;
   localparam logic [2:0] WORD_POINTER = 3'h3;
   localparam logic [2:0] WORD_ACC_HIGH = 3'h4;
   localparam logic [2:0] WORD_ACC_MID = 3'h5;
   localparam logic [2:0] WORD_ACC_LOW = 3'h6;
   localparam logic [1:0] FUNC_DOUBLE_LOAD = 2'h1;
   localparam logic [15:0] WORD_ZERO = 16'h0000;
   localparam logic [15:0] ONE_WORD = 16'h0001;
   typedef enum logic [3:0] {
      SEQ_HALT = 4'h0,
      SEQ_NEXT = 4'h1,
      SEQ_FETCH = 4'h2,
      SEQ_INDEX = 4'h3,
      SEQ_STOP_WAIT = 4'h4,
      SEQ_STOP_SETUP = 4'h5,
      SEQ_SAVE = 4'h6,
      SEQ_SAVE_END = 4'h7,
      SEQ_RST_SETUP = 4'h8,
      SEQ_RESTORE = 4'h9,
      SEQ_RST_FINISH = 4'ha
   } seq_state_type;
   typedef enum logic [1:0] {
      MEM_IDLE = 2'h0,
      MEM_REQ = 2'h1,
      MEM_RESP = 2'h2
   } mem_phase_type;
endpackage : fpu_seq_pkg
`default_nettype wire

// ### fp_mem_model.sv
// Memory-side model of the direct memory channel
`default_nettype none
module fp_mem_model (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Memory channel
   input wire logic memReq,
   input wire logic memWrite,
   input wire logic [15:0] memAddr,
   input wire logic [15:0] memWdata,
   output logic [15:0] memRdata,
   output logic memResume,
   // Answer speed
   input wire logic slow
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] mem [0:255];
   int ncyc;
   int waitQ;
   int holdQ;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         memResume <= 1'b0;
         memRdata <= 16'h0000;
         {waitQ, holdQ, ncyc} <= '0;
      end else if (memReq && !memResume) begin
         if (waitQ >= (slow ? 4 : 0)) begin
            memResume <= 1'b1;
            if (memWrite) mem[memAddr[7:0]] <= memWdata;
            else memRdata <= mem[memAddr[7:0]];
         end else waitQ <= waitQ + 1;
      end else if (!memReq && memResume) begin
         memResume <= 1'b0;
         {waitQ, holdQ} <= '0;
         ncyc <= ncyc + 1;
      end else if (!memResume && holdQ < 4) begin
         // Hold data past the receiver's sync, then invert it
         holdQ <= holdQ + 1;
         if (holdQ == 3) memRdata <= ~memRdata;
      end
   end
endmodule : fp_mem_model
`default_nettype wire

// ### index_ops_context_save_restore_tb.sv
// Self-checking bench for the index and save/restore sequencer
`default_nettype none
module index_ops_context_save_restore_tb;
   import fpu_seq_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, reset_n, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdv, rnd;
   logic memReq, memWrite, memResume, scannerHold, consecutiveCycle;
   logic [15:0] memAddr, memWdata, memRdata, accHigh, accMid, accLow;
   logic arithBusy, arithOverflow, arithStart, slow, errSeen;
   logic [1:0] arithFunc;
   logic [1:0] funcSeen;
   logic startSeen = 1'b0;
   logic [19:0] mdHigh;
   logic [15:0] mdMid, mdLow, ptr, tmp, idx;
   int error_cnt = 0;
   int comparisons = 0;
   int n0;
   index_ops_context_save_restore i_index_ops_context_save_restore (
      .clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr),
      .memWdata(memWdata), .memRdata(memRdata), .memResume(memResume),
      .scannerHold(scannerHold), .consecutiveCycle(consecutiveCycle),
      .arithBusy(arithBusy), .arithDivFault(1'b0),
      .arithOverflow(arithOverflow), .arithUnderflow(1'b0),
      .accHigh(accHigh), .accMid(accMid), .accLow(accLow),
      .arithStart(arithStart), .arithFunc(arithFunc), .mdHigh(mdHigh),
      .mdMid(mdMid), .mdLow(mdLow));
   fp_mem_model i_fp_mem_model (
      .clk(clk), .reset_n(reset_n), .memReq(memReq), .memWrite(memWrite),
      .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata),
      .memResume(memResume), .slow(slow));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   function automatic logic [19:0] signExt(input logic [15:0] w);
      return {{4{w[15]}}, w};
   endfunction : signExt
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic end_sim;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_sim
   // Setup cycle, then access held until pready
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdv = prdata;
      errSeen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Memory cycles are counted; the wait is bounded at 3000 clocks
   task automatic waitmem(input int n);
      int target;
      int k;
      target = i_fp_mem_model.ncyc + n;
      k = 0;
      while (i_fp_mem_model.ncyc < target && k < 3000) begin
         @(posedge clk);
         k++;
      end
      repeat (20) @(posedge clk);
      chk(i_fp_mem_model.ncyc, target);
   endtask : waitmem
   function automatic logic [31:0] mw(input logic [7:0] a);
      return {16'h0000, i_fp_mem_model.mem[a]};
   endfunction : mw
   always @(posedge clk) begin
      if (arithStart === 1'b1) begin
         startSeen <= 1'b1;
         funcSeen <= arithFunc;
      end
   end
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      end_sim();
   end
   initial begin
      {reset_n, psel, penable, pwrite, slow, arithBusy, arithOverflow} = '0;
      {paddr, pwdata, accHigh, accMid, accLow} = '0;
      rnd = 32'h5269;
      idx = 16'h0000;
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      for (int op = 0; op < 3; op++) begin
         rnd = lfsr(rnd);
         // Pointer writes are ignored once active; pointer steps by one
         ptr = 16'h0010 + 16'(op);
         tmp = ptr + 16'h0020 + 16'(rnd[3:0]);
         i_fp_mem_model.mem[ptr[7:0]] = tmp - ptr;
         i_fp_mem_model.mem[tmp[7:0]] = rnd[31:16];
         slow <= rnd[4];
         apb(1'b1, ADDR_POINTER, {16'h0000, ptr});
         apb(1'b1, ADDR_COMMAND, {26'h0, (op == 0) ? 4'h4 : 4'h1, 2'(op)});
         waitmem(2);
         if (op == 0) idx = rnd[31:16];
         if (op == 1) idx = idx + rnd[31:16];
         apb(1'b0, ADDR_INDEX, 32'h0);
         chk(rdv, {16'h0000, idx});
         apb(1'b0, ADDR_TEMP_ADDR, 32'h0);
         chk(rdv, {16'h0000, tmp});
      end
      chk(mw(tmp[7:0]), {16'h0000, idx});
      rnd = lfsr(rnd);
      accHigh <= rnd[15:0];
      accMid <= rnd[31:16];
      accLow <= rnd[23:8];
      @(posedge clk);
      arithOverflow <= 1'b1;
      @(posedge clk);
      arithOverflow <= 1'b0;
      arithBusy <= 1'b1;
      n0 = i_fp_mem_model.ncyc;
      apb(1'b1, ADDR_STOP, 32'h80);
      apb(1'b1, ADDR_COMMAND, 32'h06);
      repeat (10) @(posedge clk);
      chk(i_fp_mem_model.ncyc, n0);
      arithBusy <= 1'b0;
      waitmem(7);
      chk(mw(8'h80) & 32'h10, 32'h10);
      chk(mw(8'h81) & 32'h3f, 32'h06);
      chk(mw(8'h82), {16'h0000, idx});
      chk(mw(8'h83), {16'h0000, ptr + 16'h0001});
      chk({16'(mw(8'h84)), 16'(mw(8'h85))}, {accHigh, accMid});
      chk(mw(8'h86), {16'h0000, accLow});
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rdv & 32'h3, 32'h2);
      // Restart from an altered save area, saved status inactive
      rnd = lfsr(rnd);
      i_fp_mem_model.mem[8'h80] = 16'h0010;
      for (int i = 2; i < 7; i++) begin
         i_fp_mem_model.mem[8'h80 + i] = rnd[15:0] + 16'(i * 3);
      end
      i_fp_mem_model.mem[8'h84] = rnd[31:16] | 16'h8000;
      apb(1'b1, ADDR_RESTART, 32'h0);
      waitmem(7);
      apb(1'b0, ADDR_COMMAND, 32'h0);
      chk(rdv & 32'h3f, 32'h06);
      apb(1'b0, ADDR_INDEX, 32'h0);
      chk(rdv, mw(8'h82));
      apb(1'b0, ADDR_POINTER, 32'h0);
      chk(rdv, mw(8'h83));
      chk({12'h000, mdHigh}, {12'h000, signExt(16'(mw(8'h84)))});
      chk({mdMid, mdLow}, {16'(mw(8'h85)), 16'(mw(8'h86))});
      chk({startSeen, funcSeen}, {1'b1, FUNC_DOUBLE_LOAD});
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rdv & 32'h39, 32'h10);
      apb(1'b0, ADDR_SAVE_AREA, 32'h0);
      chk(rdv, 32'h80);
      // Stop arriving mid-command waits, then saves
      slow <= 1'b1;
      i_fp_mem_model.mem[8'h10] = 16'h0020;
      i_fp_mem_model.mem[8'h30] = rnd[15:0];
      apb(1'b1, ADDR_POINTER, 32'h10);
      apb(1'b1, ADDR_COMMAND, 32'h04);
      apb(1'b1, ADDR_STOP, 32'ha0);
      apb(1'b1, ADDR_COMMAND, 32'h04);
      waitmem(9);
      chk(mw(8'ha6), {16'h0000, accLow});
      apb(1'b0, ADDR_SAVE_AREA, 32'h0);
      chk(rdv, 32'ha0);
      // Stop while halted starts at once
      apb(1'b1, ADDR_STOP, 32'hb0);
      waitmem(7);
      chk(mw(8'hb1), 32'h04);
      apb(1'b0, 8'h20, 32'h0);
      chk({rdv[30:0], errSeen}, 32'h1);
      end_sim();
   end
endmodule : index_ops_context_save_restore_tb
`default_nettype wire
